// file: pkg/wfp_pkg.sv
// wfp_pkg: constants for the wake frame payload configuration block.
// assumes a 200 MHz system clock and 7-bit serial register addresses.
package wfp_pkg;
  // register addresses as seen on the serial configuration port
  localparam logic [6:0] OFF_BYTE6 = 7'h2d;
  localparam logic [6:0] OFF_BYTE5 = 7'h2e;
  localparam logic [6:0] OFF_BYTE4 = 7'h2f;
  localparam logic [6:0] OFF_BYTE3 = 7'h30;
  localparam logic [6:0] OFF_BYTE2 = 7'h31;
  localparam logic [6:0] OFF_BYTE1 = 7'h32;
  localparam logic [6:0] OFF_BYTE0 = 7'h33;
  localparam logic [6:0] OFF_TOL_CTRL = 7'h34;
  localparam logic [6:0] OFF_OSC_TRIM = 7'h38;
  // payload bytes held by this block
  localparam int NUM_BYTES = 7;
  // tolerant-mode control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FILT_LSB = 1;
  localparam int CTRL_FILT_MSB = 3;
  localparam int CTRL_BYP_BIT = 4;
  localparam int CTRL_SUP_BIT = 5;
  localparam int CTRL_WIDTH = 6;
  // reset values after power-on or soft reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // trim write unlock code
  localparam logic [1:0] TRIM_UNLOCK = 2'h3;
  localparam logic [2:0] FILT_CODE_LONG = 3'h7;
  // serial frame: 7 address bits, write flag, 8 data bits
  localparam int FRAME_BITS = 16;
  localparam int HALF_BITS = 8;
  localparam int WR_BIT = 8;
  // dominant filter timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int FILT_STEP_NS = 50;
  localparam int FILT_LONG_NS = 775;
  localparam int FILT_STEP_CYC =
    (FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_LONG_CYC =
    (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W = 8;
endpackage

// file: rtl/wfp_sync2.sv
// wfp_sync2: two-flop synchroniser, one per bit.
// assumes inputs come from pins or a foreign domain; reset is async low.
`timescale 1ns/10ps
module wfp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  // both stages kept together; the first stage feeds only the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } wfp_sync_st_t;

  wfp_sync_st_t st_reg;
  wfp_sync_st_t st_next;

  // next state: shift one stage per clock
  always_comb begin
    st_next = st_reg;
    st_next.meta = d_in;
    st_next.stable = st_reg.meta;
  end

  // register stages
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.stable;
endmodule

// file: rtl/wfp_dom_filter.sv
// wfp_dom_filter: dominant pulse filter on the received bus level.
// assumes rx_in is already synchronous; low is dominant.
`timescale 1ns/10ps
module wfp_dom_filter #(
  parameter int STEP_CYC = wfp_pkg::FILT_STEP_CYC,
  parameter int LONG_CYC = wfp_pkg::FILT_LONG_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rx_in,
  input wire logic [2:0] code_in,
  output logic rx_out
);
  localparam int CW = wfp_pkg::FILT_CNT_W;

  typedef struct packed {
    logic [CW-1:0] cnt; // cycles of dominant seen so far
    logic rx;           // filtered level
  } wfp_filt_st_t;

  wfp_filt_st_t st_reg;
  wfp_filt_st_t st_next;
  logic [CW-1:0] limit;

  // pass a dominant level only after it has lasted the filter time
  always_comb begin
    st_next = st_reg;
    // 50 ns per code step, longest code is a fixed 775 ns [R9]
    if (code_in == wfp_pkg::FILT_CODE_LONG) begin
      limit = CW'(LONG_CYC);
    end else begin
      limit = CW'((int'(code_in) + 1) * STEP_CYC);
    end
    if (rx_in) begin
      // recessive ends the pulse at once
      st_next.cnt = '0;
      st_next.rx = 1'b1;
    end else if (st_reg.cnt >= limit - CW'(1)) begin
      st_next.rx = 1'b0;
    end else begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  // register filter state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '{cnt: '0, rx: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx_out = st_reg.rx;
endmodule

// file: rtl/wfp_top.sv
// wfp_top: wake frame payload and tolerant-mode configuration registers,
// reached over the serial configuration port, plus the receive path
// switches they steer.
// assumes spi pins and rx pins are asynchronous to sys_clk_in; trim
// enable, wake activity and silence timeout come from same-clock logic.
// there is no restart input: restart leaves every stored value alone,
// which is allowed because its values are unspecified.
// every output of the block comes straight from a flip-flop.
//
// Notes on behaviour
// R1: payload bytes zero to six, full 8 bits
// R2: payload clears on reset, untouched on restart
// R3: control clears on reset, upper two zero
// R4: control bits 7:6 read zero, ignore writes
// R5: suppress bit pauses error counter in tolerant
// R6: silence timeout clears suppress bit by hardware
// R7: bypass bit routes rx around analog filter
// R8: dominant filter active regardless of bypass
// R9: filter time 50 ns steps, 111 is 775
// R10: bit zero enables tolerant mode
// R11: trim writes accepted only when enable is 11
// R12: trim register has no reset value
// R13: low five trim bits are monotonic fine trim
// R14: upper trim bits set temperature coefficient
// R15: changing trim values is optional
// R16: reads return stored value, no side effect
`timescale 1ns/10ps
module wfp_top (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // serial configuration port
  input wire logic spi_csn_in,
  input wire logic spi_sck_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  // miso enable: low while this block drives the line
  output logic spi_miso_oe_n_out,
  // same-clock system inputs
  input wire logic [1:0] trim_enable_in,
  input wire logic selective_wake_active_in,
  // one-cycle pulse from the bus silence monitor
  input wire logic silence_timeout_in,
  // receive path pins
  // both copies of the bus level; low is dominant
  input wire logic rx_raw_in,
  input wire logic rx_analog_filtered_in,
  // configuration towards the wake decoder and oscillator, plus the filtered rx level
  output logic [7:0] payload_byte_zero_out,
  output logic [7:0] payload_byte_one_out,
  output logic [7:0] payload_byte_two_out,
  output logic [7:0] payload_byte_three_out,
  output logic [7:0] payload_byte_four_out,
  output logic [7:0] payload_byte_five_out,
  output logic [7:0] payload_byte_six_out,
  output logic tolerant_mode_enable_out,
  output logic receiver_filter_bypass_out,
  output logic [2:0] dominant_pulse_filter_time_out,
  // error counter suspend, one cycle behind its causes
  output logic error_counter_suspend_out,
  output logic [7:0] oscillator_trim_value_out,
  output logic rx_wake_data_out
);
  // byte slots walked by the read mux and the write decode
  localparam int NB = wfp_pkg::NUM_BYTES;
  // control bits that are really stored; 7:6 have no flops
  localparam int CW = wfp_pkg::CTRL_WIDTH;

  // released reset, synchronous deassertion
  logic rst_n;
  // synchronised serial pins: csn, sck, mosi
  logic [2:0] spi_sync;
  // synchronised rx pins: raw, analog filtered
  logic [1:0] rx_sync;
  // level chosen ahead of the dominant filter
  logic rx_sel;
  // dominant filter result
  logic rx_filt;

  // all state of the block outside the synchronisers and the dominant filter
  // trim shares the struct but is left out of the reset branch
  typedef struct packed {
    logic csn_prev;              // csn of last cycle
    logic sck_prev;              // sck of last cycle
    logic [4:0] bit_cnt;         // bits taken in this frame
    logic [15:0] shift_in;       // incoming frame
    logic [7:0] shift_out;       // read data being sent
    logic miso;                  // miso level
    logic miso_oe_n;             // low while driving miso
    logic [NB-1:0][7:0] payload; // index 0 is byte zero
    logic [CW-1:0] ctrl;         // tolerant-mode control
    logic [7:0] trim;            // oscillator trim, never reset
    logic suspend;               // error counter suspend
    logic rx_wake;               // rx to the wake decoder
  } wfp_st_t;

  wfp_st_t st_reg;
  wfp_st_t st_next;

  // comb scratch for the serial engine
  // pin levels after the synchroniser
  logic csn;
  logic sck;
  logic mosi;
  // one-cycle strobes on sck edges while selected
  logic sck_rise;
  logic sck_fall;
  // frame with this cycle's mosi bit shifted in
  logic [15:0] shifted;
  // fields of the finished frame
  logic [6:0] addr;
  logic [7:0] wdata;
  // one-cycle pulse that applies a finished write frame
  logic wr_commit;

  // reset release: async assert, two-flop deassert
  // the copy falls with the pin at once but rises only after two
  // clean edges, so no flop leaves reset on a metastable level
  wfp_sync2 #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .d_in(1'b1),
    .q_out(rst_n)
  );

  // serial pins cross into the clock domain; idle csn is high
  // so the engine stays deselected until the pins have settled
  wfp_sync2 #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_spi_sync (
    .clk_in(sys_clk_in),
    .nrst_in(rst_n),
    .d_in({spi_csn_in, spi_sck_in, spi_mosi_in}),
    .q_out(spi_sync)
  );

  // rx pins cross in too; idle bus is recessive
  // so no false dominant is seen just after reset
  wfp_sync2 #(
    .WIDTH(2),
    .RST_VAL(2'h3)
  ) u_rx_sync (
    .clk_in(sys_clk_in),
    .nrst_in(rst_n),
    .d_in({rx_raw_in, rx_analog_filtered_in}),
    .q_out(rx_sync)
  );

  // bypass set: take the raw level around the analog filter [R7]
  // limitation: flipping bypass during a dominant pulse may cut
  // or stretch that pulse as the filter sees it
  assign rx_sel = st_reg.ctrl[wfp_pkg::CTRL_BYP_BIT] ? rx_sync[1]
                                                     : rx_sync[0];

  // dominant filter sits after the mux, so bypass never skips it [R8]
  // a new filter code applies from the cycle after its write
  wfp_dom_filter #(
    .STEP_CYC(wfp_pkg::FILT_STEP_CYC),
    .LONG_CYC(wfp_pkg::FILT_LONG_CYC)
  ) u_dom_filter (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .rx_in(rx_sel),
    .code_in(st_reg.ctrl[wfp_pkg::CTRL_FILT_MSB:wfp_pkg::CTRL_FILT_LSB]),
    .rx_out(rx_filt)
  );

  // read mux: pure decode, reading changes nothing [R16]
  // bytes sit at falling addresses, byte zero highest; unmapped
  // addresses fall through to zero
  function automatic logic [7:0] rd_mux(input logic [6:0] a,
                                        input wfp_st_t s);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NB; i++) begin
      if (a == wfp_pkg::OFF_BYTE0 - 7'(i)) begin
        r = s.payload[i];
      end
    end
    if (a == wfp_pkg::OFF_TOL_CTRL) begin
      // reserved upper bits always come back zero [R4]
      r = {2'h0, s.ctrl};
    end
    if (a == wfp_pkg::OFF_OSC_TRIM) begin
      r = s.trim;
    end
    return r;
  endfunction

  // serial engine, register writes and output staging
  always_comb begin
    st_next = st_reg;
    // pin copies after the two-flop synchroniser
    csn = spi_sync[2];
    sck = spi_sync[1];
    mosi = spi_sync[0];
    // edges count only while selected, so stray sck toggles between
    // frames never reach the shift register
    sck_rise = !csn && sck && !st_reg.sck_prev;
    sck_fall = !csn && !sck && st_reg.sck_prev;
    // msb-first shift and the frame fields it yields
    shifted = {st_reg.shift_in[14:0], mosi};
    addr = st_reg.shift_in[15:9];
    wdata = st_reg.shift_in[7:0];
    wr_commit = 1'b0;
    // levels kept for next cycle's edge detection
    st_next.csn_prev = csn;
    st_next.sck_prev = sck;

    if (csn) begin
      // deselected: release miso and start the next frame fresh
      st_next.miso_oe_n = 1'b1;
      st_next.miso = 1'b0;
      st_next.bit_cnt = '0;
      // a cut frame leaves the count below 16 and is refused here
      // only a complete frame with the write flag stores data
      if (!st_reg.csn_prev &&
          st_reg.bit_cnt == 5'(wfp_pkg::FRAME_BITS) &&
          st_reg.shift_in[wfp_pkg::WR_BIT]) begin
        wr_commit = 1'b1;
      end
    end else begin
      // selected: drive miso; the first byte goes out as zeros
      st_next.miso_oe_n = 1'b0;
      // bits past the sixteenth are not taken, so an over-long frame keeps
      // its first 16 bits and still passes the count check at csn rise
      if (sck_rise && st_reg.bit_cnt < 5'(wfp_pkg::FRAME_BITS)) begin
        // sample mosi, msb first
        st_next.shift_in = shifted;
        st_next.bit_cnt = st_reg.bit_cnt + 5'h1;
        // after the first byte the address is known: fetch data
        // the byte is snapshot here so a later write cannot tear it
        if (st_reg.bit_cnt == 5'(wfp_pkg::HALF_BITS - 1)) begin
          st_next.shift_out = rd_mux(shifted[7:1], st_reg);
        end
      end
      if (sck_fall) begin
        if (st_reg.bit_cnt >= 5'(wfp_pkg::HALF_BITS)) begin
          // second byte carries the register contents
          st_next.miso = st_reg.shift_out[7];
          st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
        end else begin
          // first byte: nothing to report yet
          st_next.miso = 1'b0;
        end
      end
    end

    // the write lands a cycle after csn is seen high, when address
    // and data can no longer move
    if (wr_commit) begin
      // payload bytes take all eight bits, bit 0 the lsb [R1]
      for (int i = 0; i < NB; i++) begin
        if (addr == wfp_pkg::OFF_BYTE0 - 7'(i)) begin
          st_next.payload[i] = wdata;
        end
      end
      // control keeps only its six defined bits [R4] [R10]
      if (addr == wfp_pkg::OFF_TOL_CTRL) begin
        st_next.ctrl = wdata[CW-1:0];
      end
      // trim is locked unless the enable field is 11 [R11]
      // a locked write is dropped silently; nothing flags it
      if (addr == wfp_pkg::OFF_OSC_TRIM &&
          trim_enable_in == wfp_pkg::TRIM_UNLOCK) begin
        // all eight bits stored as written; fine and coefficient
        // bits are passed to the oscillator untouched [R13] [R14]
        st_next.trim = wdata;
      end
    end

    // silence timeout clears the suppress bit; it wins over a write
    // landing in the same cycle, so the counter is never left paused
    if (silence_timeout_in) begin
      st_next.ctrl[wfp_pkg::CTRL_SUP_BIT] = 1'b0; // [R6]
    end

    // suppress only counts while tolerant mode is on and wake runs [R5]
    // registered so the port comes from a flop, one cycle late
    st_next.suspend = st_reg.ctrl[wfp_pkg::CTRL_SUP_BIT] &&
                      st_reg.ctrl[wfp_pkg::CTRL_EN_BIT] &&
                      selective_wake_active_in;
    // filtered level registered once more for the output port
    st_next.rx_wake = rx_filt;
  end

  // state register; trim is left out of the reset branch on purpose,
  // so it keeps whatever was loaded before [R12]
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      // every field but trim goes to its idle value; trim simply holds
      st_reg.csn_prev <= 1'b1;
      st_reg.sck_prev <= 1'b0;
      st_reg.bit_cnt <= '0;
      st_reg.shift_in <= 16'h0000;
      st_reg.shift_out <= 8'h00;
      st_reg.miso <= 1'b0;
      st_reg.miso_oe_n <= 1'b1;
      st_reg.payload <= {NB{wfp_pkg::BYTE_RST}}; // [R2]
      st_reg.ctrl <= wfp_pkg::CTRL_RST; // [R3]
      st_reg.suspend <= 1'b0;
      st_reg.rx_wake <= 1'b1;
    end else begin
      st_reg.csn_prev <= st_next.csn_prev;
      st_reg.sck_prev <= st_next.sck_prev;
      st_reg.bit_cnt <= st_next.bit_cnt;
      st_reg.shift_in <= st_next.shift_in;
      st_reg.shift_out <= st_next.shift_out;
      st_reg.miso <= st_next.miso;
      st_reg.miso_oe_n <= st_next.miso_oe_n;
      st_reg.payload <= st_next.payload;
      st_reg.ctrl <= st_next.ctrl;
      st_reg.suspend <= st_next.suspend;
      st_reg.rx_wake <= st_next.rx_wake;
      // trim shares this process so st_reg has a single driver; only
      // an unlocked write changes it
      st_reg.trim <= st_next.trim;
    end
  end

  // outputs straight from the state flops
  assign spi_miso_out = st_reg.miso;
  assign spi_miso_oe_n_out = st_reg.miso_oe_n;
  assign payload_byte_zero_out = st_reg.payload[0];
  assign payload_byte_one_out = st_reg.payload[1];
  assign payload_byte_two_out = st_reg.payload[2];
  assign payload_byte_three_out = st_reg.payload[3];
  assign payload_byte_four_out = st_reg.payload[4];
  assign payload_byte_five_out = st_reg.payload[5];
  assign payload_byte_six_out = st_reg.payload[6];
  // control fields split out to their own ports
  assign tolerant_mode_enable_out = st_reg.ctrl[wfp_pkg::CTRL_EN_BIT];
  assign receiver_filter_bypass_out = st_reg.ctrl[wfp_pkg::CTRL_BYP_BIT];
  assign dominant_pulse_filter_time_out =
    st_reg.ctrl[wfp_pkg::CTRL_FILT_MSB:wfp_pkg::CTRL_FILT_LSB];
  // suspend and rx level were registered in the state above
  assign error_counter_suspend_out = st_reg.suspend;
  assign oscillator_trim_value_out = st_reg.trim;
  assign rx_wake_data_out = st_reg.rx_wake;
endmodule

// file: testbench/wfp_props.sv
// wfp_props: timing checker for the wake frame payload configuration block.
// assumes it is bound to wfp_top and sees only that module's ports.
`timescale 1ns/10ps
module wfp_checker (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic spi_csn_in,
  input wire logic spi_miso_oe_n_out,
  input wire logic [1:0] trim_enable_in,
  input wire logic selective_wake_active_in,
  input wire logic silence_timeout_in,
  input wire logic rx_raw_in,
  input wire logic rx_analog_filtered_in,
  input wire logic [7:0] payload_byte_zero_out,
  input wire logic [7:0] payload_byte_six_out,
  input wire logic tolerant_mode_enable_out,
  input wire logic receiver_filter_bypass_out,
  input wire logic [2:0] dominant_pulse_filter_time_out,
  input wire logic error_counter_suspend_out,
  input wire logic [7:0] oscillator_trim_value_out,
  input wire logic rx_wake_data_out
);
  logic [8:0] low_cnt_reg; // cycles the selected rx line has been low
  logic [3:0] csn_hi_reg; // cycles chip select has been high, saturating
  logic rx_sel; // the rx line the bypass bit picks
  assign rx_sel = receiver_filter_bypass_out ? rx_raw_in
                                             : rx_analog_filtered_in;
  // helper counters; saturate so long idle stretches never wrap
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_cnt_reg <= 9'h000;
      csn_hi_reg <= 4'h0;
    end else begin
      low_cnt_reg <= rx_sel ? 9'h000 : low_cnt_reg + 9'(low_cnt_reg != 9'h1ff);
      csn_hi_reg <= !spi_csn_in ? 4'h0 : csn_hi_reg + 4'(csn_hi_reg != 4'hf);
    end
  end
  // dominant filter threshold in cycles: 50 ns steps, code 7 is 775 ns
  function automatic int thr(input logic [2:0] c);
    return (c == 3'h7) ? 775 / 5 : (int'(c) + 1) * 50 / 5;
  endfunction
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // hardware clear of the suppress bit reaches the suspend output in 2
  sequence s_cleared;
    ##2 !error_counter_suspend_out;
  endsequence
  AST_RST_CLEAR: assert property (disable iff (1'b0) !nrst_in |->
    payload_byte_zero_out == 8'h00 && payload_byte_six_out == 8'h00 &&
    !tolerant_mode_enable_out && !error_counter_suspend_out)
    else $error("outputs not cleared in reset");
  AST_SUP_CAUSE: assert property (error_counter_suspend_out |->
    $past(tolerant_mode_enable_out) && $past(selective_wake_active_in))
    else $error("suspend without tolerant mode and wake");
  AST_SUP_NOWAKE: assert property (!$past(selective_wake_active_in) |->
    !error_counter_suspend_out) else $error("suspend outside wake");
  AST_SUP_TIMEOUT: assert property (silence_timeout_in |-> s_cleared)
    else $error("suspend survived silence timeout");
  AST_TRIM_LOCK: assert property (trim_enable_in != 2'b11 |=>
    $stable(oscillator_trim_value_out)) else $error("trim changed locked");
  AST_FILT_FALL: assert property ($fell(rx_wake_data_out) |->
    low_cnt_reg >= thr(dominant_pulse_filter_time_out) + 1 &&
    low_cnt_reg <= thr(dominant_pulse_filter_time_out) + 6)
    else $error("dominant passed at wrong time");
  AST_FILT_RISE: assert property ($rose(rx_wake_data_out) |->
    low_cnt_reg == 9'h000) else $error("recessive while line low");
  AST_CFG_STABLE: assert property (csn_hi_reg == 4'hf |=>
    $stable({payload_byte_zero_out, payload_byte_six_out,
    tolerant_mode_enable_out, receiver_filter_bypass_out,
    dominant_pulse_filter_time_out})) else $error("config changed idle");
  AST_OE_IDLE: assert property (csn_hi_reg >= 4'h6 |-> spi_miso_oe_n_out)
    else $error("miso driven while deselected");
endmodule
bind wfp_top wfp_checker u_chk (.*);

// file: testbench/wfp_can_rx_model.sv
// wfp_can_rx_model: bus receiver seen from the block, raw and filtered.
// assumes the bench calls pulse() just after a falling clock edge.
`timescale 1ns/10ps
module wfp_can_rx_model #(
  parameter int ANALOG_MIN = 40 // analog filter swallows shorter lows
) (
  input wire logic clk_in,
  output logic rx_raw_out,
  output logic rx_filt_out
);
  int low_run = 0; // length of the current dominant stretch
  initial begin
    rx_raw_out = 1'b1;
    rx_filt_out = 1'b1;
  end
  // one dominant bit of len cycles, then recessive again
  task automatic pulse(input int len);
    rx_raw_out <= 1'b0;
    repeat (len) @(negedge clk_in);
    rx_raw_out <= 1'b1;
  endtask
  // analog path: dominant shows only after ANALOG_MIN low cycles
  always @(negedge clk_in) begin
    low_run = rx_raw_out ? 0 : low_run + 1;
    rx_filt_out <= (low_run <= ANALOG_MIN);
  end
endmodule

// file: testbench/wake_frame_payload_config_tb_top.sv
// wake_frame_payload_config_tb_top: self-checking bench for wfp_top.
// assumes wfp_pkg, wfp_top, the checker and the rx model are compiled.
`timescale 1ns/10ps
module wake_frame_payload_config_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b1; // active low reset, pulled low at 1 ns
  logic csn = 1'b1; // active low select
  logic sck = 1'b0;
  logic mosi = 1'b0;
  logic [1:0] trim_en = 2'b11; // unlocked until trim holds a value
  logic wake = 1'b0;
  logic silence = 1'b0;
  logic miso, oe_n, rx_raw, rx_filt, en, byp, sup, rx_wake;
  logic [2:0] filt;
  logic [7:0] trim, t, rd_val;
  logic [7:0] pay [0:6];
  logic [7:0] v [0:6];
  logic rd_stb = 1'b0;
  logic seen_low = 1'b0;
  logic [7:0] exp_q [$]; // expected read bytes, oldest first
  int miscompares = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  wfp_top u_dut (.sys_clk_in(clk), .nrst_in(nrst), .spi_csn_in(csn),
    .spi_sck_in(sck), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_n_out(oe_n), .trim_enable_in(trim_en),
    .selective_wake_active_in(wake), .silence_timeout_in(silence),
    .rx_raw_in(rx_raw), .rx_analog_filtered_in(rx_filt),
    .payload_byte_zero_out(pay[0]), .payload_byte_one_out(pay[1]),
    .payload_byte_two_out(pay[2]), .payload_byte_three_out(pay[3]),
    .payload_byte_four_out(pay[4]), .payload_byte_five_out(pay[5]),
    .payload_byte_six_out(pay[6]), .tolerant_mode_enable_out(en),
    .receiver_filter_bypass_out(byp),
    .dominant_pulse_filter_time_out(filt),
    .error_counter_suspend_out(sup), .oscillator_trim_value_out(trim),
    .rx_wake_data_out(rx_wake));
  wfp_can_rx_model u_can (.clk_in(clk), .rx_raw_out(rx_raw),
    .rx_filt_out(rx_filt));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic summarize();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one 16-bit frame; sck phases of 4 clocks, miso taken before each rise of the second byte
  task automatic spi(input logic [6:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] r);
    logic [15:0] f;
    f = {a, w, d};
    r = 8'h00;
    csn = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      mosi = f[i];
      repeat (4) @(negedge clk);
      if (i < 8) r = {r[6:0], miso};
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    csn = 1'b1;
    repeat (8) @(negedge clk); // commit lands about 3 clocks after csn
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi(a, 1'b1, d, r);
  endtask
  // read notes the expected byte, the monitor below compares
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    spi(a, 1'b0, 8'($urandom), rd_val);
    exp_q.push_back(e);
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
  endtask
  always @(posedge clk) begin
    if (rd_stb) check("read", rd_val, exp_q.pop_front());
    if (rx_wake === 1'b0) seen_low <= 1'b1;
  end
  // bounded wait for the suspend output; running out ends the run
  task automatic wait_sup(input logic e);
    for (int n = 0; n < 8 && sup !== e; n++) @(negedge clk);
    if (sup !== e) begin
      miscompares++;
      summarize();
    end
    check("suspend", {7'h00, sup}, {7'h00, e});
  endtask
  // dominant pulse on the bus, then report whether it got through
  task automatic dom(input int len, input logic pass);
    seen_low = 1'b0;
    u_can.pulse(len);
    repeat (12) @(negedge clk);
    check("rx pass", {7'h00, seen_low}, {7'h00, pass});
  endtask
  initial begin
    void'($urandom(32'h2f5e));
    #1 nrst = 1'b0; // a real falling edge puts every flop but trim in reset
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    for (int k = 0; k < 7; k++) check("payload", pay[k], 8'h00);
    check("ctrl", {3'h0, byp, filt, en}, 8'h00);
    // trim: write unlocked, then locked write must be dropped
    t = {3'b101, 5'($urandom)}; // upper bits kept fixed
    wr(wfp_pkg::OFF_OSC_TRIM, t);
    trim_en = 2'($urandom_range(2, 0));
    wr(wfp_pkg::OFF_OSC_TRIM, t ^ 8'h1f);
    check("trim", trim, t);
    rd(wfp_pkg::OFF_OSC_TRIM, t);
    for (int k = 0; k < 7; k++) begin
      v[k] = 8'($urandom);
      wr(7'(wfp_pkg::OFF_BYTE0 - k), v[k]);
      check("payload", pay[k], v[k]);
    end
    for (int k = 6; k >= 0; k--) rd(7'(wfp_pkg::OFF_BYTE0 - k), v[k]);
    wr(7'h35, 8'hff);
    rd(7'h35, 8'h00);
    wr(wfp_pkg::OFF_TOL_CTRL, 8'hff);
    rd(wfp_pkg::OFF_TOL_CTRL, 8'h3f);
    check("ctrl", {3'h0, byp, filt, en}, 8'h1f);
    wake = 1'b1;
    wait_sup(1'b1);
    wake = 1'b0;
    wait_sup(1'b0);
    wake = 1'b1;
    wr(wfp_pkg::OFF_TOL_CTRL, 8'h3e);
    wait_sup(1'b0);
    wr(wfp_pkg::OFF_TOL_CTRL, 8'h21);
    wait_sup(1'b1);
    silence = 1'b1;
    @(negedge clk);
    silence = 1'b0;
    wait_sup(1'b0);
    rd(wfp_pkg::OFF_TOL_CTRL, 8'h01);
    wake = 1'b0;
    // every filter code, just below and above its threshold, bypassed
    for (int c = 0; c < 8; c++) begin
      wr(wfp_pkg::OFF_TOL_CTRL, {3'h0, 1'b1, 3'(c), 1'b0});
      dom((c == 7) ? 775 / 5 - 4 : (c + 1) * 10 - 4, 1'b0);
      dom((c == 7) ? 775 / 5 + 8 : (c + 1) * 10 + 8, 1'b1);
    end
    // analog path swallows a short low, bypass lets it through
    wr(wfp_pkg::OFF_TOL_CTRL, 8'h00);
    dom(30, 1'b0);
    dom(80, 1'b1);
    wr(wfp_pkg::OFF_TOL_CTRL, 8'h10);
    dom(30, 1'b1);
    // second reset: payload clears, trim kept, never retuned
    nrst = 1'b0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    for (int k = 0; k < 7; k++) check("payload", pay[k], 8'h00);
    check("trim", trim, t);
    summarize();
  end
endmodule
